// ### logic/mpgc_gain_ctrl.sv
// microphone pga gain control with wishbone registers
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/100ps
module mpgc_gain_ctrl #(
  parameter int unsigned STEP_CYC = mpgc_pkg::STEP_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [6:0] agc_gain_in,
  input wire logic [15:0] adc_data_in,
  output logic [15:0] adc_data_out,
  output logic [1:0] mic_bias_level,
  output logic mic_bias_on,
  output logic [6:0] pga_gain_applied,
  output logic pga_muted,
  output logic signed [8:0] eff_gain_lp,
  output logic signed [8:0] eff_gain_rp,
  output logic signed [8:0] eff_gain_lm,
  output logic adc_power_on,
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] bias;
    logic [7:0] gain;
    logic [7:0] rsel;
    logic [7:0] adc;
    logic [7:0] mute;
    logic [7:0] agc;
    logic [6:0] applied;
    logic muted;
    logic powered;
    logic reached;
    logic [mpgc_pkg::CNT_W-1:0] cnt;
    logic ack;
    logic [7:0] dat;
    logic [mpgc_pkg::EV_W-1:0] sts;
    logic [mpgc_pkg::EV_W-1:0] ien;
    logic [15:0] adc_out;
    logic signed [8:0] eff_lp;
    logic signed [8:0] eff_rp;
    logic signed [8:0] eff_lm;
  } mpgc_state_t;

  mpgc_state_t s_reg;
  mpgc_state_t s_next;

  function automatic logic signed [8:0] offs(input logic [1:0] code);
    unique case (code)
      2'b00: offs = 9'sh000;
      2'b01: offs = mpgc_pkg::OFFS_6DB;
      2'b10, 2'b11: offs = -mpgc_pkg::OFFS_6DB;
    endcase
  endfunction

  logic tick;
  logic soft_on;
  logic pga_en;
  logic pwr_req;
  logic [6:0] fixed_gain;
  logic [6:0] loop_gain;
  logic [6:0] tgt;
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [mpgc_pkg::EV_W-1:0] ev;
  logic reached_now;
  logic [7:0] rd;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    idx = wb_adr_i[9:2];
    req = wb_cyc_i && wb_stb_i;
    // a write lands on the edge where ack is seen high
    wr = req && wb_we_i && wb_sel_i[0] && s_reg.ack;
    tick = (s_reg.cnt == mpgc_pkg::CNT_W'(STEP_CYC - 1));
    soft_on = !s_reg.adc[mpgc_pkg::SOFT_OFF_BIT];
    pga_en = s_reg.gain[mpgc_pkg::TOP_BIT];
    pwr_req = s_reg.adc[mpgc_pkg::TOP_BIT];
    // codes above the top step are clamped rather than wrapped
    fixed_gain = (s_reg.gain[6:0] > mpgc_pkg::GAIN_MAX) ? mpgc_pkg::GAIN_MAX : s_reg.gain[6:0];
    loop_gain = (agc_gain_in > mpgc_pkg::GAIN_MAX) ? mpgc_pkg::GAIN_MAX : agc_gain_in;
    if (!pga_en) begin
      tgt = mpgc_pkg::GAIN_ZERO;
    end else if (s_reg.agc[mpgc_pkg::TOP_BIT]) begin
      tgt = loop_gain;
    end else begin
      tgt = fixed_gain;
    end
    ev = '0;

    s_next.cnt = tick ? '0 : s_reg.cnt + mpgc_pkg::CNT_W'(1);

    // soft-step engine: mute is reached only from 0 dB, walked down to with soft stepping on and jumped to with it off
    if (tick || !soft_on) begin
      if (!pwr_req) begin
        if (s_reg.applied == mpgc_pkg::GAIN_ZERO) begin
          s_next.muted = 1'b1;
        end else if (soft_on) begin
          s_next.applied = s_reg.applied - mpgc_pkg::GAIN_STEP;
        end else begin
          s_next.applied = mpgc_pkg::GAIN_ZERO;
        end
      end else if (s_reg.muted) begin
        s_next.muted = 1'b0;
      end else if (!soft_on) begin
        s_next.applied = tgt;
      end else if (s_reg.applied < tgt) begin
        s_next.applied = s_reg.applied + mpgc_pkg::GAIN_STEP;
      end else if (s_reg.applied > tgt) begin
        s_next.applied = s_reg.applied - mpgc_pkg::GAIN_STEP;
      end
    end

    // powered flag falls only once the walk to mute is done
    if (pwr_req) begin
      s_next.powered = 1'b1;
    end else if (s_reg.muted) begin
      s_next.powered = 1'b0;
    end

    reached_now = pwr_req ? (!s_reg.muted && s_reg.applied == tgt) : s_reg.muted;
    s_next.reached = reached_now;

    ev[mpgc_pkg::EV_REACHED] = reached_now && !s_reg.reached;
    ev[mpgc_pkg::EV_UP] = pwr_req && !s_reg.powered;
    ev[mpgc_pkg::EV_DOWN] = !pwr_req && s_reg.muted && s_reg.powered;

    s_next.eff_lp = $signed({2'b00, s_reg.applied}) + offs(s_reg.rsel[mpgc_pkg::RSEL_LP +: 2]);
    s_next.eff_rp = $signed({2'b00, s_reg.applied}) + offs(s_reg.rsel[mpgc_pkg::RSEL_RP +: 2]);
    s_next.eff_lm = $signed({2'b00, s_reg.applied}) + offs(s_reg.rsel[mpgc_pkg::RSEL_LM +: 2]);

    if (!s_reg.mute[mpgc_pkg::TOP_BIT]) begin
      s_next.adc_out = adc_data_in;
    end

    // ---------------------------------------------------------------
    // wishbone slave
    // ---------------------------------------------------------------
    s_next.ack = req && !s_reg.ack;
    unique case (idx)
      mpgc_pkg::IDX_STATUS: rd = {s_reg.reached, s_reg.powered, 6'b00_0000};
      mpgc_pkg::IDX_BIAS: rd = {6'b00_0000, s_reg.bias};
      mpgc_pkg::IDX_GAIN: rd = s_reg.gain;
      mpgc_pkg::IDX_RSEL: rd = s_reg.rsel;
      mpgc_pkg::IDX_ADC: rd = s_reg.adc;
      mpgc_pkg::IDX_MUTE: rd = s_reg.mute;
      mpgc_pkg::IDX_AGC: rd = s_reg.agc;
      mpgc_pkg::IDX_IRQ_STS: rd = {5'b0_0000, s_reg.sts};
      mpgc_pkg::IDX_IRQ_EN: rd = {5'b0_0000, s_reg.ien};
      default: rd = mpgc_pkg::RST_BYTE;
    endcase
    if (req && !s_reg.ack) begin
      s_next.dat = wb_we_i ? mpgc_pkg::RST_BYTE : rd;
    end

    s_next.sts = s_reg.sts;
    if (wr) begin
      unique case (idx)
        mpgc_pkg::IDX_BIAS: s_next.bias = wb_dat_i[1:0];
        mpgc_pkg::IDX_GAIN: s_next.gain = wb_dat_i[7:0];
        mpgc_pkg::IDX_RSEL: s_next.rsel = wb_dat_i[7:0];
        mpgc_pkg::IDX_ADC: s_next.adc = wb_dat_i[7:0];
        mpgc_pkg::IDX_MUTE: s_next.mute = wb_dat_i[7:0];
        mpgc_pkg::IDX_AGC: s_next.agc = wb_dat_i[7:0];
        mpgc_pkg::IDX_IRQ_CLR: s_next.sts = s_reg.sts & ~wb_dat_i[mpgc_pkg::EV_W-1:0];
        mpgc_pkg::IDX_IRQ_EN: s_next.ien = wb_dat_i[mpgc_pkg::EV_W-1:0];
        default: s_next.dat = s_reg.dat;
      endcase
    end
    // a new event beats a clear in the same cycle
    s_next.sts = s_next.sts | ev;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.muted <= 1'b1;
      s_reg.reached <= 1'b1;
      s_reg.adc <= {6'b00_0000, mpgc_pkg::SOFT_RST};
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = {24'h00_0000, s_reg.dat};
  assign adc_data_out = s_reg.adc_out;
  assign mic_bias_level = s_reg.bias;
  assign mic_bias_on = (mpgc_pkg::mpgc_bias_t'(s_reg.bias) != mpgc_pkg::MPGC_BIAS_OFF);
  assign pga_gain_applied = s_reg.applied;
  assign pga_muted = s_reg.muted;
  assign eff_gain_lp = s_reg.eff_lp;
  assign eff_gain_rp = s_reg.eff_rp;
  assign eff_gain_lm = s_reg.eff_lm;
  assign adc_power_on = s_reg.powered;
  assign irq = |(s_reg.sts & s_reg.ien);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  reset_mute_a: assert property ($past(srst) |-> pga_muted && soft_on) else $error("reset not muted");
  tick_gate_a: assert property (!tick && soft_on |=> $stable(pga_gain_applied))
    else $error("gain moved off tick");
  step_up_a: assert property (tick && soft_on && pwr_req && !pga_muted && pga_gain_applied < tgt
    |=> pga_gain_applied == $past(pga_gain_applied) + mpgc_pkg::GAIN_STEP) else $error("no step up");
  pga_off_a: assert property (!pga_en && !soft_on && pwr_req && !pga_muted
    |=> pga_gain_applied == mpgc_pkg::GAIN_ZERO) else $error("disabled pga not 0 dB");
  agc_pick_a: assert property (pga_en && s_reg.agc[mpgc_pkg::TOP_BIT] && !soft_on && pwr_req && !pga_muted
    |=> pga_gain_applied == $past(loop_gain)) else $error("agc gain not used");
  reached_flag_a: assert property (s_reg.reached && pwr_req && !pga_muted && $stable(tgt)
    |-> pga_gain_applied == tgt) else $error("reached flag wrong");
  lp_offset_a: assert property (s_reg.rsel[mpgc_pkg::RSEL_LP +: 2] == 2'b01
    |=> eff_gain_lp == $signed({2'b00, $past(pga_gain_applied)}) + mpgc_pkg::OFFS_6DB) else $error("lp offset");
  mute_hold_a: assert property (s_reg.mute[mpgc_pkg::TOP_BIT] |=> $stable(adc_data_out))
    else $error("muted output moved");
  power_up_a: assert property ($rose(pwr_req) |=> adc_power_on) else $error("power flag late");
  power_down_a: assert property (adc_power_on && !pwr_req && !pga_muted |=> adc_power_on)
    else $error("powered cleared before mute");

  // ---------------------------------------------------------------
  // soft-step engine checks
  // ---------------------------------------------------------------
  step_down_a: assert property (tick && soft_on && pwr_req && !pga_muted && pga_gain_applied > tgt
    |=> pga_gain_applied == $past(pga_gain_applied) - mpgc_pkg::GAIN_STEP)
    else $error("no step down");
  walk_down_a: assert property (tick && soft_on && !pwr_req && pga_gain_applied != mpgc_pkg::GAIN_ZERO
    |=> pga_gain_applied == $past(pga_gain_applied) - mpgc_pkg::GAIN_STEP)
    else $error("no walk to mute");
  mute_reach_a: assert property (tick && !pwr_req && pga_gain_applied == mpgc_pkg::GAIN_ZERO
    |=> pga_muted)
    else $error("mute not reached");
  unmute_wait_a: assert property (pga_muted && soft_on && !tick
    |=> pga_muted)
    else $error("unmuted off tick");
  soft_off_a: assert property (!soft_on && pwr_req && !pga_muted
    |=> pga_gain_applied == $past(tgt))
    else $error("soft-off gain not direct");
  gain_clamp_a: assert property (pga_en && !s_reg.agc[mpgc_pkg::TOP_BIT]
    && s_reg.gain[6:0] > mpgc_pkg::GAIN_MAX |-> tgt == mpgc_pkg::GAIN_MAX)
    else $error("gain code not clamped");
  tick_count_a: assert property (s_reg.cnt < mpgc_pkg::CNT_W'(STEP_CYC))
    else $error("divider out of range");

  // ---------------------------------------------------------------
  // status, bias, offset and converter checks
  // ---------------------------------------------------------------
  reached_set_a: assert property (pwr_req && !pga_muted && pga_gain_applied == tgt
    |=> s_reg.reached)
    else $error("reached flag not set");
  reached_clr_a: assert property (pwr_req && pga_gain_applied != tgt
    |=> !s_reg.reached)
    else $error("reached flag not clear");
  power_off_a: assert property (!pwr_req && pga_muted && adc_power_on
    |=> !adc_power_on)
    else $error("powered flag stuck");
  bias_write_a: assert property (wr && idx == mpgc_pkg::IDX_BIAS
    |=> mic_bias_level == $past(wb_dat_i[1:0]))
    else $error("bias field not stored");
  rp_offset_a: assert property (s_reg.rsel[mpgc_pkg::RSEL_RP +: 2] == 2'h2
    |=> eff_gain_rp == $signed({2'h0, $past(pga_gain_applied)}) - mpgc_pkg::OFFS_6DB)
    else $error("rp offset");
  lm_offset_a: assert property (s_reg.rsel[mpgc_pkg::RSEL_LM +: 2] == 2'h3
    |=> eff_gain_lm == $signed({2'h0, $past(pga_gain_applied)}) - mpgc_pkg::OFFS_6DB)
    else $error("lm offset");
  mute_live_a: assert property (!s_reg.mute[mpgc_pkg::TOP_BIT]
    |=> adc_data_out == $past(adc_data_in))
    else $error("live output lags");
endmodule

// ### logic/mpgc_pkg.sv
// constants for the microphone gain control block
package mpgc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h24;
  localparam logic [7:0] IDX_BIAS = 8'h2E;
  localparam logic [7:0] IDX_GAIN = 8'h2F;
  localparam logic [7:0] IDX_RSEL = 8'h30;
  localparam logic [7:0] IDX_ADC = 8'h51;
  localparam logic [7:0] IDX_MUTE = 8'h52;
  localparam logic [7:0] IDX_AGC = 8'h56;
  localparam logic [7:0] IDX_IRQ_STS = 8'h70;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h71;
  localparam logic [7:0] IDX_IRQ_EN = 8'h72;
  // field positions
  localparam int unsigned TOP_BIT = 7;
  localparam int unsigned POWERED_BIT = 6;
  localparam int unsigned SOFT_OFF_BIT = 1;
  localparam int unsigned RSEL_LP = 6;
  localparam int unsigned RSEL_RP = 4;
  localparam int unsigned RSEL_LM = 2;
  // gain coding, half-dB steps
  localparam logic [6:0] GAIN_ZERO = 7'h00;
  localparam logic [6:0] GAIN_STEP = 7'h01;
  localparam logic [6:0] GAIN_MAX = 7'h77;
  localparam logic signed [8:0] OFFS_6DB = 9'sh00C;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] SOFT_RST = 2'h0;
  // interrupt events
  localparam int unsigned EV_W = 3;
  localparam int unsigned EV_REACHED = 0;
  localparam int unsigned EV_UP = 1;
  localparam int unsigned EV_DOWN = 2;
  // soft-step tick timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STEP_NS = 1000;
  localparam int unsigned STEP_CYC = STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 16;
  // bias level codes
  typedef enum logic [1:0] {
    MPGC_BIAS_OFF = 2'b00,
    MPGC_BIAS_2V = 2'b01,
    MPGC_BIAS_2V5 = 2'b10,
    MPGC_BIAS_SUPPLY = 2'b11
  } mpgc_bias_t;
endpackage

// ### test/test_mpgc_gain_ctrl.sv
// self-checking bench for the microphone gain control block
`timescale 1ns/100ps
module test_mpgc_gain_ctrl;
  logic ref_clk, srst, cyc, stb, we, ack, muted, pwr, irq, bias_on;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, rd;
  logic [6:0] agc_in, gain;
  logic [15:0] adc_in, adc_out;
  logic [1:0] bias;
  logic signed [8:0] e_lp, e_rp, e_lm;
  int n_errors;
  int n_tests;

  mpgc_gain_ctrl #(.STEP_CYC(4)) uut (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .agc_gain_in(agc_in), .adc_data_in(adc_in), .adc_data_out(adc_out), .mic_bias_level(bias),
    .mic_bias_on(bias_on), .pga_gain_applied(gain), .pga_muted(muted), .eff_gain_lp(e_lp),
    .eff_gain_rp(e_rp), .eff_gain_lm(e_lm), .adc_power_on(pwr), .irq(irq));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle; read data is taken at the ack edge only
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {idx, 2'h0};
    dat_i <= {24'h00_0000, d};
    do @(posedge ref_clk); while (ack !== 1'h1);
    rd = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    wb(1'h0, idx, 8'h00);
    check(what, rd, {24'h00_0000, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // follows the soft ramp, flagging any move larger than one code
  task automatic wait_gain(input logic [6:0] t);
    logic [6:0] prev;
    prev = gain;
    for (int k = 0; k < 2000 && gain !== t; k++) begin
      tick(1);
      if (gain > prev + 1 || prev > gain + 1) check("gain step", {25'h0, gain}, {25'h0, prev});
      prev = gain;
    end
    check("gain target", {25'h000_0000, gain}, {25'h000_0000, t});
  endtask

  function automatic logic signed [8:0] offs(input logic [1:0] c);
    return (c == 2'h1) ? mpgc_pkg::OFFS_6DB : (c == 2'h0) ? 9'sh000 : -mpgc_pkg::OFFS_6DB;
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    check("muted", muted, 1);
    check("gain", gain, 0);
    check("irq", irq, 0);
    rdchk("status", mpgc_pkg::IDX_STATUS, 8'h80);
    rdchk("adc ctl", mpgc_pkg::IDX_ADC, 8'h00);
    rdchk("gain reg", mpgc_pkg::IDX_GAIN, 8'h00);
    rdchk("bias reg", mpgc_pkg::IDX_BIAS, 8'h00);
  endtask

  task automatic t_bias;
    for (int i = 0; i < 4; i++) begin
      wb(1'h1, mpgc_pkg::IDX_BIAS, 8'(i));
      tick(1);
      check("bias level", bias, i);
      check("bias on", bias_on, i != 0);
    end
  endtask

  task automatic t_ramp;
    wb(1'h1, mpgc_pkg::IDX_IRQ_EN, 8'h07);
    wb(1'h1, mpgc_pkg::IDX_ADC, 8'h80);
    tick(2);
    check("power", pwr, 1);
    wb(1'h1, mpgc_pkg::IDX_GAIN, 8'h85);
    rdchk("status ramp", mpgc_pkg::IDX_STATUS, 8'h40);
    wait_gain(7'h05);
    check("unmuted", muted, 0);
    rdchk("status done", mpgc_pkg::IDX_STATUS, 8'hC0);
    rdchk("irq sts", mpgc_pkg::IDX_IRQ_STS, 8'h03);
    check("irq up", irq, 1);
    wb(1'h1, mpgc_pkg::IDX_IRQ_CLR, 8'h07);
    rdchk("irq cleared", mpgc_pkg::IDX_IRQ_STS, 8'h00);
    rdchk("clr reads", mpgc_pkg::IDX_IRQ_CLR, 8'h00);
    check("irq low", irq, 0);
  endtask

  task automatic t_rsel;
    logic [7:0] codes [3] = '{8'h6C, 8'hB4, 8'h00};
    foreach (codes[i]) begin
      wb(1'h1, mpgc_pkg::IDX_RSEL, codes[i]);
      tick(3);
      check("eff lp", 32'(e_lp), 32'(9'sh005 + offs(codes[i][7:6])));
      check("eff rp", 32'(e_rp), 32'(9'sh005 + offs(codes[i][5:4])));
      check("eff lm", 32'(e_lm), 32'(9'sh005 + offs(codes[i][3:2])));
    end
  endtask

  task automatic t_agc;
    wb(1'h1, mpgc_pkg::IDX_IRQ_EN, 8'h00);
    agc_in <= 7'h10;
    wb(1'h1, mpgc_pkg::IDX_AGC, 8'h80);
    wait_gain(7'h10);
    rdchk("masked sts", mpgc_pkg::IDX_IRQ_STS, 8'h01);
    check("masked irq", irq, 0);
    wb(1'h1, mpgc_pkg::IDX_AGC, 8'h00);
    wait_gain(7'h05);
  endtask

  task automatic t_soft_off;
    wb(1'h1, mpgc_pkg::IDX_ADC, 8'h82);
    wb(1'h1, mpgc_pkg::IDX_GAIN, 8'hFF);
    tick(2);
    check("direct max", gain, mpgc_pkg::GAIN_MAX);
    wb(1'h1, mpgc_pkg::IDX_GAIN, 8'h77);
    tick(2);
    check("pga off", gain, mpgc_pkg::GAIN_ZERO);
  endtask

  task automatic t_mute;
    @(posedge ref_clk);
    adc_in <= 16'h1234;
    wb(1'h1, mpgc_pkg::IDX_MUTE, 8'h80);
    adc_in <= 16'hABCD;
    tick(3);
    check("frozen", adc_out, 16'h1234);
    wb(1'h1, mpgc_pkg::IDX_MUTE, 8'h00);
    tick(2);
    check("live", adc_out, 16'hABCD);
  endtask

  task automatic t_power_down;
    wb(1'h1, mpgc_pkg::IDX_ADC, 8'h80);
    wb(1'h1, mpgc_pkg::IDX_GAIN, 8'h88);
    wait_gain(7'h08);
    wb(1'h1, mpgc_pkg::IDX_IRQ_CLR, 8'h07);
    wb(1'h1, mpgc_pkg::IDX_IRQ_EN, 8'h04);
    wb(1'h1, mpgc_pkg::IDX_ADC, 8'h00);
    // powered must still read set while the walk to mute runs
    rdchk("status walk", mpgc_pkg::IDX_STATUS, 8'h40);
    wait_gain(7'h00);
    // clock kept running until the powered flag reads clear; poll once before rd is trusted
    wb(1'h0, mpgc_pkg::IDX_STATUS, 8'h00);
    for (int k = 0; k < 50 && rd[6] !== 1'h0; k++) wb(1'h0, mpgc_pkg::IDX_STATUS, 8'h00);
    check("powered flag", rd[6], 0);
    check("muted", muted, 1);
    check("power", pwr, 0);
    wb(1'h0, mpgc_pkg::IDX_IRQ_STS, 8'h00);
    check("walk event", rd[2], 1);
    check("irq walk", irq, 1);
    wb(1'h1, 8'hFF, 8'h5A);
    rdchk("unmapped", 8'hFF, 8'h00);
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // the whole run needs a few hundred cycles
  initial begin
    #200000;
    n_errors++;
    report_and_stop;
  end

  initial begin
    {cyc, stb, we, adr, dat_i} = '0;
    sel = 4'h1;
    agc_in = 7'h00;
    adc_in = 16'h0000;
    srst = 1'h1;
    repeat (10) @(posedge ref_clk);
    srst <= 1'h0;
    tick(1);
    t_reset;
    t_bias;
    t_ramp;
    t_rsel;
    t_agc;
    t_soft_off;
    t_mute;
    t_power_down;
    // a second reset in mid-run must bring back the idle state
    srst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'h0;
    tick(1);
    t_reset;
    report_and_stop;
  end
endmodule
